/* pkg/vtc_pkg.sv */
// package: register map, field layout and codes of the counter control
package vtc_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses, low address bits only)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W   = 8;
    localparam logic [7:0]  OFS_ACW  = 8'h00;
    localparam logic [7:0]  OFS_CTL  = 8'h04;
    localparam logic [7:0]  OFS_STA  = 8'h08;

    // ------------------------------------------------------------
    // acquisition_control_word fields
    // ------------------------------------------------------------
    localparam int unsigned MODE_W   = 3;
    localparam int unsigned ZRM_LSB  = 0;
    localparam int unsigned CCM_LSB  = 3;
    localparam int unsigned CPM_LSB  = 6;
    localparam int unsigned THM_LSB  = 9;
    localparam int unsigned ASS_LSB  = 12;
    localparam int unsigned SWW_BIT  = 15;
    localparam logic [31:0] ACW_RST  = 32'h0000_0000;
    localparam logic [31:0] ACW_MASK = 32'h0000_FFFF;

    // ------------------------------------------------------------
    // control_word_four strobes and status layout
    // ------------------------------------------------------------
    localparam int unsigned CTL_CLR  = 0;
    localparam int unsigned CTL_SWR  = 1;
    localparam int unsigned CTL_ABT  = 2;
    localparam int unsigned STA_HS   = 16;
    localparam int unsigned STA_REL  = 19;

    // ------------------------------------------------------------
    // counter values and mode codes
    // ------------------------------------------------------------
    localparam int unsigned CNT_W    = 16;
    localparam logic [15:0] PRESET_V = 16'h8000;
    localparam logic [15:0] TOP_V    = 16'h7FF0;
    localparam logic [2:0]  M_0      = 3'h0;
    localparam logic [2:0]  M_1      = 3'h1;
    localparam logic [2:0]  M_2      = 3'h2;
    localparam logic [2:0]  M_3      = 3'h3;
    localparam logic [2:0]  M_4      = 3'h4;

    typedef enum logic [2:0] {
        VS_RUN  = 3'h1,
        VS_ZERO = 3'h2,
        VS_TOP  = 3'h4
    } vtc_hold_e;

endpackage : vtc_pkg

/* hw/vtc_sync.sv */
// two-flop synchroniser for camera-side levels
`timescale 1ns/1ps
`default_nettype none
module vtc_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // raw and synchronised levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } vtc_sync_s;

    vtc_sync_s st_q;
    vtc_sync_s st_d;

    // first stage feeds only the second
    always_comb begin
        st_d.meta = async_in;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.sync;
endmodule : vtc_sync
`default_nettype wire

/* hw/vtc_edge.sv */
// rising and falling edge strobes of same-clock levels
`timescale 1ns/1ps
`default_nettype none
module vtc_edge #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // level in, one-cycle strobes out
    input  wire logic [W-1:0] lvl,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] prev;
    } vtc_edge_s;

    vtc_edge_s st_q;
    vtc_edge_s st_d;

    always_comb begin
        st_d.prev = lvl;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rise = lvl & ~st_q.prev;
    assign fall = ~lvl & st_q.prev;
endmodule : vtc_edge
`default_nettype wire

/* hw/vtc_top.sv */
// vertical table line counter control with its AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module vtc_top #(
    parameter int unsigned CNT_W = vtc_pkg::CNT_W
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic      [31:0]      hrdata,
    // camera pins
    input  wire logic             trigger_pin,
    input  wire logic             frame_enable_pin,
    // acquisition logic, same clock
    input  wire logic             vaw_active,
    input  wire logic             line_strobe,
    input  wire logic             table_clear_column,
    input  wire logic             table_load_enable_column,
    input  wire logic             header_request,
    // results
    output logic      [CNT_W-1:0] vertical_line_counter,
    output logic      [2:0]       hold_state,
    output logic                  abort_req,
    output logic                  header_go
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]      acw;
        logic             clr_bit;
        logic             swr;
        logic             abt;
        logic             abort;
        logic [CNT_W-1:0] cnt;
        logic             released;
        logic             ap_wr;
        logic [7:0]       ap_addr;
        logic [31:0]      rdata;
    } vtc_state_s;

    vtc_state_s st_q;
    vtc_state_s st_d;

    function automatic logic [2:0] fld(input logic [31:0] w,
                                       input int unsigned lsb);
        fld = w[lsb +: vtc_pkg::MODE_W];
    endfunction : fld

    // ------------------------------------------------------------
    // pin synchronisers and edges
    // ------------------------------------------------------------
    logic [1:0] pin_s;
    logic [2:0] ev_rise;
    logic [2:0] ev_fall;
    logic       trig_s;
    logic       fen_s;

    vtc_sync #(.W(2)) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in ({frame_enable_pin, trigger_pin}),
        .sync_out (pin_s)
    );

    assign trig_s = pin_s[0];
    assign fen_s  = pin_s[1];

    vtc_edge #(.W(3)) u_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .lvl     ({vaw_active, fen_s, trig_s}),
        .rise    (ev_rise),
        .fall    (ev_fall)
    );

    logic trig_rise;
    logic trig_fall;
    logic fen_rise;
    logic vaw_end;
    assign trig_rise = ev_rise[0];
    assign trig_fall = ev_fall[0];
    assign fen_rise  = ev_rise[1];
    assign vaw_end   = ev_fall[2];

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic [2:0] zr_mode;
    logic [2:0] cc_mode;
    logic [2:0] cp_mode;
    logic [2:0] th_mode;
    logic [2:0] ab_src;
    logic       skip_wait;
    assign zr_mode   = fld(st_q.acw, vtc_pkg::ZRM_LSB);
    assign cc_mode   = fld(st_q.acw, vtc_pkg::CCM_LSB);
    assign cp_mode   = fld(st_q.acw, vtc_pkg::CPM_LSB);
    assign th_mode   = fld(st_q.acw, vtc_pkg::THM_LSB);
    assign ab_src    = fld(st_q.acw, vtc_pkg::ASS_LSB);
    assign skip_wait = st_q.acw[vtc_pkg::SWW_BIT];

    logic tbl_clr;
    logic force_clr;
    logic mode_clr;
    logic do_clr;
    logic do_pre;
    logic hold_zero;
    logic hold_top;

    // the table clear column is valid on the line strobe of its entry
    assign tbl_clr   = line_strobe && table_clear_column;
    assign force_clr = st_q.swr || st_q.abt || st_q.clr_bit;

    always_comb begin
        unique case (cc_mode)
            vtc_pkg::M_1: mode_clr = trig_fall || vaw_end;
            vtc_pkg::M_2: mode_clr = 1'b0;
            vtc_pkg::M_3: mode_clr = fen_rise;
            vtc_pkg::M_4: mode_clr = trig_fall;
            default:      mode_clr = vaw_end;
        endcase
    end

    assign do_clr = force_clr || tbl_clr || mode_clr;

    always_comb begin
        unique case (cp_mode)
            vtc_pkg::M_1: do_pre = fen_rise
                                   && table_load_enable_column;
            vtc_pkg::M_2: do_pre = fen_rise;
            vtc_pkg::M_3: do_pre = trig_rise;
            default:      do_pre = 1'b0;
        endcase
    end

    // level mode: an asserted trigger prevents sticking
    assign hold_zero = (st_q.cnt == '0) && !st_q.released
                       && ((zr_mode == vtc_pkg::M_1)
                           || ((zr_mode == vtc_pkg::M_2)
                               && !trig_s));
    assign hold_top  = (th_mode == vtc_pkg::M_1)
                       && (st_q.cnt == CNT_W'(vtc_pkg::TOP_V));

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic ap_take;
    assign ap_take = hsel && hready && htrans[1];

    vtc_pkg::vtc_hold_e hs;
    always_comb begin
        if (hold_zero) begin
            hs = vtc_pkg::VS_ZERO;
        end else if (hold_top) begin
            hs = vtc_pkg::VS_TOP;
        end else begin
            hs = vtc_pkg::VS_RUN;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d         = st_q;
        st_d.clr_bit = 1'b0;
        st_d.swr     = 1'b0;
        st_d.abt     = 1'b0;
        // host abort always, trigger fall only with source code 1
        st_d.abort   = st_q.abt
                       || ((ab_src == vtc_pkg::M_1) && trig_fall);

        // data phase of a write; command strobes act one cycle later
        if (st_q.ap_wr && (st_q.ap_addr == vtc_pkg::OFS_ACW)) begin
            st_d.acw = hwdata & vtc_pkg::ACW_MASK;
        end
        if (st_q.ap_wr && (st_q.ap_addr == vtc_pkg::OFS_CTL)) begin
            st_d.clr_bit = hwdata[vtc_pkg::CTL_CLR];
            st_d.swr     = hwdata[vtc_pkg::CTL_SWR];
            st_d.abt     = hwdata[vtc_pkg::CTL_ABT];
        end
        st_d.ap_wr   = ap_take && hwrite;
        st_d.ap_addr = haddr[vtc_pkg::ADDR_W-1:0];

        // clear beats preset beats hold beats counting
        if (do_clr) begin
            st_d.cnt = '0;
        end else if (do_pre) begin
            st_d.cnt = CNT_W'(vtc_pkg::PRESET_V);
        end else if (line_strobe && !hold_zero && !hold_top) begin
            st_d.cnt = st_q.cnt + CNT_W'(1);
        end

        // release latch: a trigger edge at zero wins over a clear
        if (do_clr) begin
            st_d.released = 1'b0;
        end
        if (trig_rise && ((st_q.cnt == '0) || do_clr)) begin
            st_d.released = 1'b1;
        end

        // read data sampled at the address phase, forwarding writes
        if (ap_take && !hwrite) begin
            if (haddr[vtc_pkg::ADDR_W-1:0] == vtc_pkg::OFS_ACW) begin
                st_d.rdata = st_d.acw;
            end else if (haddr[vtc_pkg::ADDR_W-1:0] == vtc_pkg::OFS_STA)
            begin
                st_d.rdata = '0;
                st_d.rdata[CNT_W-1:0] = st_d.cnt;
                st_d.rdata[vtc_pkg::STA_HS +: $bits(hs)] = hs;
                st_d.rdata[vtc_pkg::STA_REL] = st_d.released;
            end else begin
                // strobes read back as zero, unmapped reads too
                st_d.rdata = '0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q     <= '0;
            st_q.acw <= vtc_pkg::ACW_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout             = 1'b1;
    assign hresp                 = 1'b0;
    assign hrdata                = st_q.rdata;
    assign vertical_line_counter = st_q.cnt;
    assign hold_state            = hs;
    assign abort_req             = st_q.abort;
    assign header_go = header_request
                       && (skip_wait || vaw_active);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic quiet;
    assign quiet = !do_clr && !do_pre;

    a_free_count:
    assert property ((zr_mode == vtc_pkg::M_0) && quiet && line_strobe
                     && !hold_top |=> st_q.cnt == $past(st_q.cnt) + 1'b1)
    else $error("free mode counter did not advance");

    a_edge_sticks:
    assert property ((zr_mode == vtc_pkg::M_1) && (st_q.cnt == '0)
                     && !st_q.released && quiet |=> st_q.cnt == '0)
    else $error("edge mode counter left zero without trigger");

    a_level_runs:
    assert property ((zr_mode == vtc_pkg::M_2) && (st_q.cnt == '0)
                     && trig_s && line_strobe && quiet
                     |=> st_q.cnt != '0)
    else $error("level mode held zero with trigger high");

    a_force_clear:
    assert property (force_clr |=> st_q.cnt == '0)
    else $error("forced clear missed");

    a_window_clear:
    assert property ((cc_mode == vtc_pkg::M_0) && vaw_end
                     |=> st_q.cnt == '0)
    else $error("window end did not clear");

    a_trig_clear:
    assert property ((cc_mode == vtc_pkg::M_1) && trig_fall
                     |=> st_q.cnt == '0)
    else $error("trigger fall did not clear");

    a_table_only:
    assert property ((cc_mode == vtc_pkg::M_2) && !force_clr && !tbl_clr
                     && !do_pre && !line_strobe
                     |=> st_q.cnt == $past(st_q.cnt))
    else $error("counter changed without table clear");

    a_fen_clear:
    assert property ((cc_mode == vtc_pkg::M_3) && fen_rise
                     |=> st_q.cnt == '0)
    else $error("frame enable did not clear");

    a_fall_clear:
    assert property ((cc_mode == vtc_pkg::M_4) && trig_fall
                     |=> st_q.cnt == '0)
    else $error("trigger fall did not clear");

    a_preset_value:
    assert property (do_pre && !do_clr
                     |=> st_q.cnt == CNT_W'(vtc_pkg::PRESET_V))
    else $error("preset value wrong");

    a_top_sticks:
    assert property (hold_top && quiet
                     |=> st_q.cnt == CNT_W'(vtc_pkg::TOP_V))
    else $error("counter left top without release");

    a_trig_abort:
    assert property ((ab_src == vtc_pkg::M_1) && trig_fall |=> abort_req)
    else $error("trigger fall did not abort");

    a_header_wait:
    assert property (header_go |-> skip_wait || vaw_active)
    else $error("header ran outside window");
endmodule : vtc_top
`default_nettype wire

/* tb/vtc_cam_model.sv */
// camera side model: trigger, frame enable and line timing
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// camera and trigger source
// ----------------------------------------------------------------
module vtc_cam_model (
    // clock
    input  wire logic hclk,
    // camera outputs
    output logic      trigger_pin,
    output logic      frame_enable_pin,
    output logic      line_strobe
);
    initial begin
        trigger_pin      = 1'b0;
        frame_enable_pin = 1'b0;
        line_strobe      = 1'b0;
    end

    // six edges: two sync flops and the edge detect must see the level
    task automatic trig(input logic v);
        trigger_pin <= v;
        repeat (6) @(posedge hclk);
    endtask : trig

    task automatic frame_enable(input logic v);
        frame_enable_pin <= v;
        repeat (6) @(posedge hclk);
    endtask : frame_enable

    // back-to-back lines, one per cycle, the fastest a camera can go
    task automatic lines(input int n);
        if (n > 0) begin
            line_strobe <= 1'b1;
            repeat (n) @(posedge hclk);
            line_strobe <= 1'b0;
        end
        @(posedge hclk);
    endtask : lines
endmodule : vtc_cam_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench of the vertical counter control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, v, rng_q;
    logic [1:0]  htrans;
    logic [2:0]  hsize, hold_state;
    logic [15:0] vertical_line_counter;
    logic        trigger_pin, frame_enable_pin, line_strobe, vaw_active;
    logic        table_clear_column, table_load_enable_column;
    logic        header_request, abort_req, header_go;
    int          err_count = 0;
    int          tests_run = 0;
    int          abort_n = 0;
    int          cycles = 0;
    int          a;

    assign hready = hreadyout;

    vtc_top u_dut (
        .hclk                     (hclk),
        .hresetn                  (hresetn),
        .hsel                     (hsel),
        .haddr                    (haddr),
        .htrans                   (htrans),
        .hwrite                   (hwrite),
        .hsize                    (hsize),
        .hwdata                   (hwdata),
        .hready                   (hready),
        .hreadyout                (hreadyout),
        .hresp                    (hresp),
        .hrdata                   (hrdata),
        .trigger_pin              (trigger_pin),
        .frame_enable_pin         (frame_enable_pin),
        .vaw_active               (vaw_active),
        .line_strobe              (line_strobe),
        .table_clear_column       (table_clear_column),
        .table_load_enable_column (table_load_enable_column),
        .header_request           (header_request),
        .vertical_line_counter    (vertical_line_counter),
        .hold_state               (hold_state),
        .abort_req                (abort_req),
        .header_go                (header_go)
    );

    vtc_cam_model u_cam (
        .hclk                     (hclk),
        .trigger_pin              (trigger_pin),
        .frame_enable_pin         (frame_enable_pin),
        .line_strobe              (line_strobe)
    );

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        rng_q = rng_q ^ (rng_q << 13);
        rng_q = rng_q ^ (rng_q >> 17);
        rng_q = rng_q ^ (rng_q << 5);
        return rng_q;
    endfunction : rnd

    // 0 window end, 1 trigger fall, 2 frame enable rise
    function automatic logic exp_clr(input int m, input int e);
        case (m)
            1:       return e <= 1;
            2:       return 1'b0;
            3:       return e == 2;
            4:       return e == 1;
            default: return e == 0;
        endcase
    endfunction : exp_clr

    // 0 frame enable rise, 1 trigger rise
    function automatic logic exp_pre(input int m, input int e, input logic ld);
        return (m == 1 && e == 0 && ld) || (m == 2 && e == 0)
            || (m == 3 && e == 1);
    endfunction : exp_pre

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // address phase held until hready, then data phase until hready
    task automatic bus(input logic wr, input logic [7:0] ad,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, ad};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus

    task automatic acw(input logic [31:0] d);
        bus(1'b1, vtc_pkg::OFS_ACW, d);
    endtask : acw

    // strobes act one edge after the data phase
    task automatic ctl(input int b);
        bus(1'b1, vtc_pkg::OFS_CTL, 32'h1 << b);
        repeat (2) @(posedge hclk);
    endtask : ctl

    task automatic sta(input logic [15:0] c, input logic [2:0] h);
        bus(1'b0, vtc_pkg::OFS_STA, 32'h0);
        chk({16'h0, rd[15:0]}, {16'h0, c});
        chk({29'h0, rd[18:16]}, {29'h0, h});
        chk({16'h0, vertical_line_counter}, {16'h0, c});
        chk({29'h0, hold_state}, {29'h0, h});
    endtask : sta

    task automatic print_verdict();
        $display("errors %0d, comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // the longest scenario climbs to the top value, about 33k cycles
    always @(posedge hclk) begin
        cycles++;
        if (abort_req === 1'b1) abort_n <= abort_n + 1;
        if (cycles == 60000) begin
            err_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        rng_q = 32'h0000_0020;
        {hresetn, hsel, hwrite, vaw_active, header_request} = 5'h00;
        {table_clear_column, table_load_enable_column} = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, vtc_pkg::OFS_ACW, 32'h0);
        chk(rd, vtc_pkg::ACW_RST);
        bus(1'b0, vtc_pkg::OFS_CTL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, vtc_pkg::OFS_STA, rnd());
        sta(16'h0, vtc_pkg::VS_RUN);
        v = rnd();
        acw(v);
        bus(1'b0, vtc_pkg::OFS_ACW, 32'h0);
        chk(rd, v & vtc_pkg::ACW_MASK);
        for (int z = 0; z < 8; z++) begin
            if (z == 1 || z == 2) continue;
            acw(z);
            ctl(vtc_pkg::CTL_CLR);
            v = rnd() % 40 + 1;
            u_cam.lines(v);
            sta(v[15:0], vtc_pkg::VS_RUN);
        end
        acw(32'h1);
        ctl(vtc_pkg::CTL_CLR);
        u_cam.lines(4);
        sta(16'h0, vtc_pkg::VS_ZERO);
        u_cam.trig(1'b1);
        u_cam.lines(4);
        sta(16'h4, vtc_pkg::VS_RUN);
        acw(32'h2);
        ctl(vtc_pkg::CTL_CLR);
        u_cam.lines(2);
        sta(16'h2, vtc_pkg::VS_RUN);
        u_cam.trig(1'b0);
        ctl(vtc_pkg::CTL_CLR);
        u_cam.lines(2);
        sta(16'h0, vtc_pkg::VS_ZERO);
        u_cam.trig(1'b1);
        u_cam.lines(2);
        sta(16'h2, vtc_pkg::VS_RUN);
        u_cam.trig(1'b0);
        for (int m = 0; m < 8; m++) begin
            for (int e = 0; e < 3; e++) begin
                acw(m << vtc_pkg::CCM_LSB);
                if (e == 0) vaw_active <= 1'b1;
                if (e == 1) u_cam.trig(1'b1);
                ctl(vtc_pkg::CTL_CLR);
                u_cam.lines(3);
                if (e == 0) vaw_active <= 1'b0;
                if (e == 1) u_cam.trig(1'b0);
                else u_cam.frame_enable(e == 2);
                sta(exp_clr(m, e) ? 16'h0 : 16'h3,
                    vtc_pkg::VS_RUN);
                u_cam.frame_enable(1'b0);
            end
        end
        for (int m = 0; m < 8; m++) begin
            for (int e = 0; e < 2; e++) begin
                acw(m << vtc_pkg::CPM_LSB);
                ctl(vtc_pkg::CTL_CLR);
                u_cam.lines(3);
                v = rnd();
                table_load_enable_column <= v[0];
                if (e == 0) u_cam.frame_enable(1'b1);
                else u_cam.trig(1'b1);
                sta(exp_pre(m, e, v[0]) ? vtc_pkg::PRESET_V : 16'h3,
                    vtc_pkg::VS_RUN);
                u_cam.frame_enable(1'b0);
                u_cam.trig(1'b0);
            end
        end
        acw(2 << vtc_pkg::CCM_LSB);
        u_cam.lines(5);
        table_clear_column <= 1'b1;
        u_cam.lines(1);
        table_clear_column <= 1'b0;
        sta(16'h0, vtc_pkg::VS_RUN);
        u_cam.lines(4);
        ctl(vtc_pkg::CTL_SWR);
        sta(16'h0, vtc_pkg::VS_RUN);
        u_cam.lines(5);
        a = abort_n;
        ctl(vtc_pkg::CTL_ABT);
        repeat (3) @(posedge hclk);
        chk(abort_n - a, 32'h1);
        sta(16'h0, vtc_pkg::VS_RUN);
        for (int s = 0; s < 2; s++) begin
            acw(s << vtc_pkg::ASS_LSB);
            u_cam.trig(1'b1);
            a = abort_n;
            u_cam.trig(1'b0);
            chk(abort_n - a, s);
        end
        acw(1 << vtc_pkg::THM_LSB);
        ctl(vtc_pkg::CTL_CLR);
        u_cam.lines(32752 + rnd() % 8);
        sta(vtc_pkg::TOP_V, vtc_pkg::VS_TOP);
        acw(32'h0);
        u_cam.lines(1);
        sta(vtc_pkg::TOP_V + 16'h1, vtc_pkg::VS_RUN);
        for (int i = 0; i < 8; i++) begin
            acw(i[0] << vtc_pkg::SWW_BIT);
            vaw_active <= i[1];
            header_request <= i[2];
            @(posedge hclk);
            chk(header_go, i[2] & (i[0] | i[1]));
        end
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
